/* dv/orp_otp_model.sv */
// behavioural model of the one-time programmable memory
`timescale 1ns/100ps
module orp_otp_model #(
  parameter AW = 3,
  parameter [7:0] MAKER_ID = 8'h5a,
  parameter [7:0] DEVICE_ID = 8'ha7
) (
  input wire [AW-1:0] mem_addr,
  input wire chip_sel_n,
  input wire out_en_n,
  input wire [7:0] byte_out,
  input wire byte_oe,
  input wire [15:0] vcc_mv,
  input wire [15:0] vpp_mv,
  input wire [15:0] id_line_mv,
  input wire [AW-1:0] weak_addr,
  input wire [7:0] weak_need,
  input wire blank,
  input wire soft_read,
  output wire [7:0] byte_outputs
);
  logic [7:0] mem [2**AW];
  int hits [2**AW];
  logic [7:0] last_q = 8'h00;
  wire rd = !chip_sel_n && !out_en_n;
  wire id_on = id_line_mv >= 16'h2cec && id_line_mv <= 16'h30d4;
  // a marginal cell verifies at the programming supply but reads wrong at 5 V
  wire soft_bit = soft_read && vcc_mv == 16'h1388 && mem_addr == weak_addr;
  wire [7:0] rd_data = id_on ? (mem_addr[0] ? DEVICE_ID : MAKER_ID) : mem[mem_addr] ^ {7'h00, soft_bit};
  logic [AW-1:0] pa_q = '0;
  logic [7:0] pd_q = 8'h00;
  logic pen_q = 1'b0;
  always @(posedge blank) begin
    foreach (mem[i]) begin
      mem[i] = 8'hff;
      hits[i] = 0;
    end
  end
  // a weak cell only takes charge after weak_need pulses
  // pulse inputs taken at the falling edge: at the rising edge address and byte_oe move in the same step
  always @(negedge chip_sel_n) begin
    pa_q = mem_addr;
    pd_q = byte_out;
    pen_q = vpp_mv == 16'h32c8 && vcc_mv == 16'h1964 && byte_oe;
  end
  always @(posedge chip_sel_n) begin
    if (pen_q) begin
      hits[pa_q] = hits[pa_q] + 1;
      if (pa_q != weak_addr || hits[pa_q] >= weak_need) mem[pa_q] = mem[pa_q] & pd_q;
    end
    pen_q = 1'b0;
  end
  always @* if (rd) last_q = rd_data;
  // released pins show a changed value, never a kind stale one
  assign byte_outputs = rd ? rd_data : ~last_q;
endmodule

/* dv/orp_programmer_chk.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
module orp_programmer_chk #(
  parameter AW = 16,
  parameter PULSE_CYC = 10000
) (
  input wire core_clk,
  input wire arst_n,
  input wire start_prog,
  input wire start_id,
  input wire busy,
  input wire done,
  input wire pass,
  input wire fail_pulse_q,
  input wire [AW-1:0] mem_addr,
  input wire chip_sel_n,
  input wire out_en_n,
  input wire byte_oe,
  input wire [15:0] vcc_mv,
  input wire [15:0] vpp_mv,
  input wire [15:0] id_line_mv
);
  // --------
  // helpers
  // --------
  int cnt_q;
  logic [1:0] rel_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
      rel_q <= 2'h0;
    end else begin
      cnt_q <= chip_sel_n ? 0 : cnt_q + 1;
      rel_q <= (rel_q == 2'h3) ? rel_q : rel_q + 2'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // starts are ignored for two edges after reset release
  sequence idle_s; !busy && rel_q >= 2'h2; endsequence
  pulse_len_a: assert property ($rose(chip_sel_n) && $past(byte_oe) |-> cnt_q == PULSE_CYC)
    else $error("pulse width");
  prog_setup_a: assert property (start_prog ##0 idle_s |=> busy && vcc_mv == 16'h1964 && mem_addr == '0)
    else $error("program setup");
  pulse_volt_a: assert property ($fell(chip_sel_n) && byte_oe |-> vpp_mv == 16'h32c8)
    else $error("pulse voltage");
  vcc_first_a: assert property (vpp_mv != 16'h0 |-> vcc_mv == 16'h1964)
    else $error("supply order");
  no_clash_a: assert property (!out_en_n |-> !byte_oe)
    else $error("data contention");
  id_setup_a: assert property (start_id && !start_prog ##0 idle_s |=> id_line_mv == 16'h2ee0)
    else $error("id setup");
  fail_end_a: assert property (fail_pulse_q |-> ##[0:2] (!busy && done && !pass))
    else $error("fail stop");
  end_low_a: assert property ($fell(busy) |-> vpp_mv == 16'h0 && byte_oe == 1'b0)
    else $error("end levels");
endmodule
bind orp_programmer orp_programmer_chk #(.AW(AW), .PULSE_CYC(PULSE_CYC)) i_chk (.core_clk(core_clk),
  .arst_n(arst_n), .start_prog(start_prog), .start_id(start_id), .busy(busy), .done(done), .pass(pass),
  .fail_pulse_q(fail_pulse_q), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .byte_oe(byte_oe), .vcc_mv(vcc_mv), .vpp_mv(vpp_mv), .id_line_mv(id_line_mv));

/* dv/orp_programmer_tb.sv */
// self-checking bench for the sequencer against the memory model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module orp_programmer_tb;
  localparam AW = 3;
  localparam [7:0] MAKER_ID = 8'h5a; // arbitrary value
  localparam [7:0] DEVICE_ID = 8'ha7; // arbitrary value
  logic core_clk = 1'b0, arst_n = 1'b0, start_prog = 1'b0, start_id = 1'b0, blank = 1'b0;
  logic soft_read = 1'b0;
  logic [AW-1:0] weak_addr = 3'h0;
  logic [7:0] weak_need = 8'h01;
  int n_mismatch = 0, check_count = 0, n_fail = 0;
  wire [AW-1:0] src_addr, fail_addr, mem_addr;
  wire [7:0] maker_code, device_code, byte_out, byte_outputs, src_data;
  wire [15:0] vcc_mv, vpp_mv, id_line_mv;
  wire busy, done, pass, fail_pulse_q, chip_sel_n, out_en_n, byte_oe;
  function automatic [7:0] pat(input [AW-1:0] a);
    pat = {a, 5'h0a} ^ 8'h93;
  endfunction
  assign src_data = pat(src_addr);
  orp_programmer #(.AW(AW), .PULSE_CYC(20), .SETUP_CYC(4), .DV_CYC(3)) i_orp_programmer (.core_clk(core_clk),
    .arst_n(arst_n), .start_prog(start_prog), .start_id(start_id), .last_addr(3'h7), .src_data(src_data),
    .src_addr(src_addr), .busy(busy), .done(done), .pass(pass), .fail_pulse_q(fail_pulse_q),
    .fail_addr(fail_addr), .maker_code(maker_code), .device_code(device_code), .mem_addr(mem_addr),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .byte_out(byte_out), .byte_oe(byte_oe),
    .byte_outputs(byte_outputs), .vcc_mv(vcc_mv), .vpp_mv(vpp_mv), .id_line_mv(id_line_mv));
  orp_otp_model #(.AW(AW), .MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) i_orp_otp_model (.mem_addr(mem_addr),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .byte_out(byte_out), .byte_oe(byte_oe), .vcc_mv(vcc_mv),
    .vpp_mv(vpp_mv), .id_line_mv(id_line_mv), .weak_addr(weak_addr), .weak_need(weak_need), .blank(blank),
    .soft_read(soft_read), .byte_outputs(byte_outputs));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fail_pulse_q === 1'b1) n_fail++;
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // starts one sequence; a second start while busy must be ignored
  task automatic go(input logic prog, input [AW-1:0] waddr, input [7:0] need);
    int k;
    weak_addr = waddr;
    weak_need = need;
    blank = prog;
    @(posedge core_clk) #1;
    blank = 1'b0;
    start_prog = prog;
    start_id = !prog;
    @(posedge core_clk) #1;
    start_prog = !prog;
    start_id = prog;
    @(posedge core_clk) #1;
    start_prog = 1'b0;
    start_id = 1'b0;
    `CHK("busy start", 16'h0, prog ? id_line_mv : vpp_mv)
    for (k = 0; k < 20000 && !(busy === 1'b0 && done === 1'b1); k++) @(posedge core_clk) #1;
    if (k == 20000) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic t_prog(input [AW-1:0] waddr, input [7:0] need, input logic ok);
    int f0;
    f0 = n_fail;
    go(1'b1, waddr, need);
    `CHK("pass", ok, pass)
    `CHK("fail pulses", ok ? f0 : f0 + 1, n_fail)
    `CHK("weak pulses", ok ? int'(need) : 11, i_orp_otp_model.hits[waddr])
    `CHK("next pulses", 1, i_orp_otp_model.hits[waddr + 3'h1])
    if (!ok) `CHK("fail address", waddr, fail_addr)
    for (int a = 0; a < 8; a++) if (ok) `CHK("cell", pat(a[2:0]), i_orp_otp_model.mem[a])
  endtask
  // one retry at a cell that then fails only the 5 V read-back; follows a failed run on purpose
  task automatic t_readback(input [AW-1:0] waddr);
    int f0;
    f0 = n_fail;
    soft_read = 1'b1;
    go(1'b1, waddr, 8'd2);
    soft_read = 1'b0;
    `CHK("readback pass", 1'b0, pass)
    `CHK("readback address", waddr, fail_addr)
    `CHK("readback fail pulses", f0, n_fail)
    `CHK("retry after failed run", 2, i_orp_otp_model.hits[waddr])
  endtask
  task automatic t_id();
    go(1'b0, 3'h0, 8'h01);
    `CHK("maker code", MAKER_ID, maker_code)
    `CHK("device code", DEVICE_ID, device_code)
    `CHK("id pass", 1'b1, pass)
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    t_prog(3'h2, 8'd6, 1'b1);
    t_prog(3'h5, 8'd11, 1'b1);
    t_prog(3'h4, 8'd12, 1'b0);
    t_readback(3'h3);
    t_id();
    complete_run();
  end
endmodule

/* hw/orp_programmer.v */
// programmer-side sequencer for a 64k x 8 one-time programmable memory
`timescale 1ns/100ps
`include "orp_regs.vh"
module orp_programmer #(
  parameter AW = 16,
  parameter PULSE_CYC = `ORP_PULSE_CYC,
  parameter SETUP_CYC = `ORP_SETUP_CYC,
  parameter DV_CYC = `ORP_DV_CYC,
  parameter MAX_RETRY = `ORP_MAX_RETRY
) (
  input wire core_clk,
  input wire arst_n,
  input wire start_prog,
  input wire start_id,
  input wire [AW-1:0] last_addr,
  input wire [7:0] src_data,
  output wire [AW-1:0] src_addr,
  output reg busy,
  output reg done,
  output reg pass,
  output reg fail_pulse_q,
  output reg [AW-1:0] fail_addr,
  output reg [7:0] maker_code,
  output reg [7:0] device_code,
  output reg [AW-1:0] mem_addr,
  output reg chip_sel_n,
  output reg out_en_n,
  output reg [7:0] byte_out,
  output reg byte_oe,
  input wire [7:0] byte_outputs,
  output reg [15:0] vcc_mv,
  output reg [15:0] vpp_mv,
  output reg [15:0] id_line_mv
);
  // --------------------------------------------------------------
  // reset and input synchronisers
  // --------------------------------------------------------------
  reg rst_s1_q, rst_n_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  reg [7:0] rd_s1_q, rd_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_s1_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      rd_s1_q <= byte_outputs;
      rd_q <= rd_s1_q;
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  localparam S_IDLE = 4'h0, S_RAMP = 4'h1, S_P1_SET = 4'h2, S_P1_PULSE = 4'h3,
    S_VF_SET = 4'h4, S_VF_RD = 4'h5, S_VF_PULSE = 4'h6, S_LOWER = 4'h7,
    S_RB_RD = 4'h8, S_ID_SET = 4'h9, S_ID_RD = 4'ha, S_END = 4'hb;
  reg [3:0] st_q;
  reg [31:0] tmr_q;
  reg [3:0] retry_q;
  reg pass_q;
  assign src_addr = mem_addr;

  function [31:0] lim;
    input [31:0] c;
    begin
      lim = (c == 32'd0) ? 32'd0 : c - 32'd1;
    end
  endfunction

  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= S_IDLE;
      tmr_q <= 32'd0;
      retry_q <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      pass_q <= 1'b0;
      fail_pulse_q <= 1'b0;
      fail_addr <= {AW{1'b0}};
      maker_code <= 8'h00;
      device_code <= 8'h00;
      mem_addr <= {AW{1'b0}};
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      byte_out <= 8'h00;
      byte_oe <= 1'b0;
      vcc_mv <= 16'h0000;
      vpp_mv <= 16'h0000;
      id_line_mv <= 16'h0000;
    end else begin
      fail_pulse_q <= 1'b0;
      tmr_q <= tmr_q + 32'd1;
      case (st_q)
        S_IDLE: begin
          tmr_q <= 32'd0;
          if (start_prog) begin
            busy <= 1'b1;
            done <= 1'b0;
            pass <= 1'b0;
            // a failed run leaves the retry count at its limit
            retry_q <= 4'h0;
            mem_addr <= {AW{1'b0}};
            vcc_mv <= 16'd`ORP_MV_VCC_PROG;
            vpp_mv <= 16'd`ORP_MV_VPP_PROG;
            st_q <= S_RAMP;
          end else if (start_id) begin
            busy <= 1'b1;
            done <= 1'b0;
            vcc_mv <= 16'd`ORP_MV_VCC_READ;
            id_line_mv <= 16'd`ORP_MV_VID;
            mem_addr <= {AW{1'b0}};
            st_q <= S_ID_SET;
          end
        end
        // supplies settle before the first pulse
        S_RAMP: if (tmr_q >= lim(SETUP_CYC)) begin
          tmr_q <= 32'd0;
          byte_out <= src_data;
          byte_oe <= 1'b1;
          st_q <= S_P1_SET;
        end
        S_P1_SET: if (tmr_q >= lim(SETUP_CYC)) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b0;
          st_q <= S_P1_PULSE;
        end
        S_P1_PULSE: if (tmr_q >= lim(PULSE_CYC)) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b1;
          if (mem_addr == last_addr) begin
            mem_addr <= {AW{1'b0}};
            byte_oe <= 1'b0;
            st_q <= S_VF_SET;
          end else begin
            mem_addr <= mem_addr + {{(AW-1){1'b0}}, 1'b1};
            st_q <= S_RAMP;
          end
        end
        // data bus released; wait hold time then read
        S_VF_SET: if (tmr_q >= lim(SETUP_CYC)) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b0;
          out_en_n <= 1'b0;
          st_q <= S_VF_RD;
        end
        // two sync stages included in the data-valid wait
        S_VF_RD: if (tmr_q >= lim(DV_CYC) + 32'd2) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b1;
          out_en_n <= 1'b1;
          if (rd_q == src_data) begin
            retry_q <= 4'h0;
            if (mem_addr == last_addr) begin
              vpp_mv <= 16'h0000;
              vcc_mv <= 16'd`ORP_MV_VCC_READ;
              mem_addr <= {AW{1'b0}};
              pass_q <= 1'b1;
              st_q <= S_LOWER;
            end else begin
              mem_addr <= mem_addr + {{(AW-1){1'b0}}, 1'b1};
              st_q <= S_VF_SET;
            end
          end else if (retry_q == MAX_RETRY[3:0]) begin
            fail_addr <= mem_addr;
            fail_pulse_q <= 1'b1;
            vpp_mv <= 16'h0000;
            vcc_mv <= 16'h0000;
            st_q <= S_END;
          end else begin
            retry_q <= retry_q + 4'h1;
            byte_out <= src_data;
            byte_oe <= 1'b1;
            st_q <= S_VF_PULSE;
          end
        end
        // setup then pulse, reuses the timer in one state; the hold follows in S_VF_SET
        S_VF_PULSE: begin
          if (tmr_q == lim(SETUP_CYC)) begin
            chip_sel_n <= 1'b0;
          end
          if (tmr_q == lim(SETUP_CYC) + PULSE_CYC) begin
            chip_sel_n <= 1'b1;
            byte_oe <= 1'b0;
            tmr_q <= 32'd0;
            st_q <= S_VF_SET;
          end
        end
        S_LOWER: if (tmr_q >= lim(SETUP_CYC)) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b0;
          out_en_n <= 1'b0;
          st_q <= S_RB_RD;
        end
        S_RB_RD: if (tmr_q >= lim(DV_CYC) + 32'd2) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b1;
          out_en_n <= 1'b1;
          if (rd_q != src_data) begin
            pass_q <= 1'b0;
            if (pass_q) begin
              fail_addr <= mem_addr;
            end
          end
          if (mem_addr == last_addr) begin
            st_q <= S_END;
          end else begin
            mem_addr <= mem_addr + {{(AW-1){1'b0}}, 1'b1};
            st_q <= S_LOWER;
          end
        end
        S_ID_SET: if (tmr_q >= lim(SETUP_CYC)) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b0;
          out_en_n <= 1'b0;
          st_q <= S_ID_RD;
        end
        S_ID_RD: if (tmr_q >= lim(DV_CYC) + 32'd2) begin
          tmr_q <= 32'd0;
          chip_sel_n <= 1'b1;
          out_en_n <= 1'b1;
          if (mem_addr[0]) begin
            device_code <= rd_q;
            id_line_mv <= 16'h0000;
            pass_q <= 1'b1;
            st_q <= S_END;
          end else begin
            maker_code <= rd_q;
            mem_addr <= {{(AW-1){1'b0}}, 1'b1};
            st_q <= S_ID_SET;
          end
        end
        S_END: begin
          busy <= 1'b0;
          done <= 1'b1;
          pass <= pass_q;
          pass_q <= 1'b0;
          vcc_mv <= 16'h0000;
          vpp_mv <= 16'h0000;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

/* hw/orp_regs.vh */
// constants for the one-time programmable memory programming sequencer
// Operation
// - program each byte with a low chip-select pulse, 100 us nominal, 95 to 105 us.
// - start the sequence with the address set to the first location.
// - raise core supply to 6.5 V and programming pin to 13.0 V first.
// - first pass: one unverified program pulse on every address.
// - second pass: verify each address; failing byte gets up to 10 pulses, each verified.
// - byte still failing after 10 extra pulses: stop and report device failed.
// - advance to next address once the byte verifies, until all are checked.
// - then programming pin low, core supply 5.0 V, read and compare every byte.
// - identification mode while the id address line is held at 11.5 to 12.5 V.
`ifndef ORP_REGS_VH
`define ORP_REGS_VH
`define ORP_CLK_MHZ 100
`define ORP_PULSE_US 100
`define ORP_PULSE_CYC (`ORP_PULSE_US * `ORP_CLK_MHZ)
`define ORP_SETUP_US 2
`define ORP_SETUP_CYC (`ORP_SETUP_US * `ORP_CLK_MHZ)
`define ORP_DV_US 1
`define ORP_DV_CYC (`ORP_DV_US * `ORP_CLK_MHZ)
`define ORP_MAX_RETRY 10
`define ORP_MV_VCC_PROG 6500
`define ORP_MV_VPP_PROG 13000
`define ORP_MV_VCC_READ 5000
`define ORP_MV_VID 12000
`endif
